//--- logic/cbs_defines.vh
`ifndef CBS_DEFINES_VH
`define CBS_DEFINES_VH

// position of the wake oscillator enable in the second configuration byte
`define CBS_WOE_BIT        0

// reset values of the stored selects and of the bank status
`define CBS_SEL_A_RST      1'h0
`define CBS_SEL_B_RST      1'h0
`define CBS_STATUS_RST     1'h1

// device state codes, also driven out on dev_state
`define CBS_ST_OFF         2'h0
`define CBS_ST_A           2'h1
`define CBS_ST_B           2'h2

// schedule phases of the wake oscillator
`define CBS_PH_OFF         1'h0
`define CBS_PH_ON          1'h1

// timing tick of the duration counter
`define CBS_CLK_PERIOD_NS  10
`define CBS_TICK_NS        1000
`define CBS_TICK_CYC       (`CBS_TICK_NS / `CBS_CLK_PERIOD_NS)
`define CBS_PRE_W          7

`endif

//--- logic/cbs_timer.v
`timescale 1ns/1ps
`include "cbs_defines.vh"

// duration counter: a fixed tick prescaler and a 4-bit down-counter.
// a duration of field value n lasts n+1 ticks, so a zero field never stalls
module cbs_timer (
  core_clk,
  rst,
  load,
  load_val,
  done
);
  input  wire       core_clk;
  input  wire       rst;
  input  wire       load;
  input  wire [3:0] load_val;
  output wire       done;

  reg [`CBS_PRE_W-1:0] pre_r;
  reg [3:0]            cnt_r;
  wire                 tick;

  assign tick = (pre_r == `CBS_TICK_CYC - 1);
  // no load term here: the reload that done causes must not feed back into done
  assign done = tick & (cnt_r == 4'h0);

  // prescaler restarts with each load so every period starts on a full tick
  always @(posedge core_clk) begin
    if (rst || load || tick) begin
      pre_r <= {`CBS_PRE_W{1'h0}};
    end else begin
      pre_r <= pre_r + 1'h1;
    end
  end

  // reload at the start of each state, count down on ticks
  always @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (tick && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule

//--- logic/cbs_ctrl.v
// Behaviour
// - select B low gives bank A; A low, B high gives B; both high alternate.
// - bank status bit reads the same through either bank.
// - bank status is 1 for bank A active, 0 for bank B active.
// - oscillator off and pin high: only single-bank selects pick the bank.
// - new selects take effect when config select returns high.
// - oscillator off, host-driven wake pin switches device off and on.
// - wake pin low puts device OFF in every scheme except oscillator mode with the pin undriven.
// - a message in progress holds state A or B until it ends.
// - wake-pin dual mode: status inverts on each wake pin falling edge.
// - any SPI access in dual mode restarts the sequence at state A.
// - oscillator enable set: internal oscillator schedules ON and OFF.
// - driven wake pin overrides oscillator; undriven pin leaves oscillator in charge.
// - oscillator dual mode: status inverts at end of each A or B period.
// - pin forced high in oscillator mode freezes bank and stops toggling.
// - A timed by bank A on time, B by bank B, OFF by bank A.
// - pin high enters ON of current status bank until release and message end.
// - pin released while OFF: the running OFF period completes first.
// - stretched or cut states do not shift the following schedule.
// - all configuration and status bits reachable through the SPI port.
// - power-on reset loads defaults into selects and status.
// - oscillator enable is bit 0 of the second configuration register.
`timescale 1ns/1ps
`include "cbs_defines.vh"

module cbs_ctrl (
  core_clk,
  rst,
  bank_a_select,
  bank_b_select,
  config2_a,
  tx_mode_flag,
  on_time_field_a,
  on_time_field_b,
  off_time_field_a,
  config_select_n,
  wake_pin,
  wake_pin_driven,
  spi_access,
  msg_active,
  active_bank_status,
  dev_state,
  dev_on,
  cfg_bank_b,
  sched_on
);
  input  wire       core_clk;
  input  wire       rst;
  input  wire       bank_a_select;
  input  wire       bank_b_select;
  input  wire [7:0] config2_a;
  input  wire       tx_mode_flag;
  input  wire [3:0] on_time_field_a;
  input  wire [3:0] on_time_field_b;
  input  wire [2:0] off_time_field_a;
  input  wire       config_select_n;
  input  wire       wake_pin;
  input  wire       wake_pin_driven;
  input  wire       spi_access;
  input  wire       msg_active;
  output wire       active_bank_status;
  output wire [1:0] dev_state;
  output wire       dev_on;
  output wire       cfg_bank_b;
  output wire       sched_on;

  // synchroniser stages; first stages feed only the second stages
  reg        wake_m_r;
  reg        wake_s_r;
  reg        wake_d_r;
  reg        cfgn_m_r;
  reg        cfgn_s_r;
  reg        cfgn_d_r;

  // applied bank selects and bank status
  reg        sel_a_r;
  reg        sel_b_r;
  reg        status_r;
  reg        status_nxt;

  // device state and oscillator schedule
  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg        phase_r;
  reg        phase_nxt;
  reg        osc_en_d_r;

  wire       wake_fall;
  wire       cfg_exit;
  wire       cfg_mode;
  wire       osc_en;
  wire       dual;
  wire       forced_hi;
  reg        want_on;
  wire       t_done;
  reg        t_load;
  reg  [3:0] t_val;
  wire       hold;
  wire       exit_status;

  // wake pin: two flops, third flop only for edge detection
  always @(posedge core_clk) begin
    if (rst) begin
      wake_m_r <= 1'h0;
      wake_s_r <= 1'h0;
      wake_d_r <= 1'h0;
    end else begin
      wake_m_r <= wake_pin;
      wake_s_r <= wake_m_r;
      wake_d_r <= wake_s_r;
    end
  end

  // config select: reset to its idle high level so reset makes no false exit
  always @(posedge core_clk) begin
    if (rst) begin
      cfgn_m_r <= 1'h1;
      cfgn_s_r <= 1'h1;
      cfgn_d_r <= 1'h1;
    end else begin
      cfgn_m_r <= config_select_n;
      cfgn_s_r <= cfgn_m_r;
      cfgn_d_r <= cfgn_s_r;
    end
  end

  assign wake_fall = wake_d_r & ~wake_s_r;
  assign cfg_exit  = ~cfgn_d_r & cfgn_s_r;
  assign cfg_mode  = ~cfgn_s_r & wake_s_r;

  // oscillator enable bit of the second configuration register
  assign osc_en    = config2_a[`CBS_WOE_BIT];

  // dual bank only with both selects set; transmitter use is the host's duty
  assign dual      = sel_a_r & sel_b_r;

  // status that the selects being applied give: A unless only B is chosen
  assign exit_status = bank_a_select | ~bank_b_select;

  // a driven-high pin in oscillator mode freezes the bank
  assign forced_hi = osc_en & wake_pin_driven & wake_s_r;

  // whether the device should be ON right now.
  // a driven pin overrides the oscillator, an undriven pin leaves it in charge;
  // with the oscillator on the undriven pin level is not read, since a floating input means nothing
  always @* begin
    want_on = 1'h0;
    if (!osc_en) begin
      want_on = wake_s_r;
    end else if (wake_pin_driven) begin
      want_on = wake_s_r;
    end else begin
      want_on = (phase_r == `CBS_PH_ON);
    end
  end

  // a message keeps the present ON state alive
  assign hold      = msg_active & (state_r != `CBS_ST_OFF);

  // selects are taken only when configuration mode ends, never mid-access.
  // single-bank combinations alone matter in direct control with the pin held high
  always @(posedge core_clk) begin
    if (rst) begin
      sel_a_r <= `CBS_SEL_A_RST;
      sel_b_r <= `CBS_SEL_B_RST;
    end else if (cfg_exit) begin
      sel_a_r <= bank_a_select;
      sel_b_r <= bank_b_select;
    end
  end

  // bank status: fixed by single selects, toggled in dual mode.
  // the exit takes the value of the selects being applied, so a move into
  // dual mode restarts at A at once instead of keeping the old single bank
  always @* begin
    status_nxt = status_r;
    if (cfg_exit) begin
      status_nxt = exit_status;
    end else if (!dual) begin
      status_nxt = ~sel_b_r;
    end else if (spi_access) begin
      status_nxt = 1'h1;
    end else if (forced_hi) begin
      status_nxt = status_r;
    end else if (!osc_en && wake_fall) begin
      status_nxt = ~status_r;
    end else if (osc_en && phase_r == `CBS_PH_ON && t_done) begin
      status_nxt = ~status_r;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      status_r <= `CBS_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // oscillator schedule runs on its own timer whatever the device does,
  // so a held or forced state never shifts later periods
  always @* begin
    phase_nxt = phase_r;
    if (!osc_en) begin
      phase_nxt = `CBS_PH_OFF;
    end else if (t_done) begin
      phase_nxt = ~phase_r;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      phase_r <= `CBS_PH_OFF;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // delayed enable marks the first cycle of oscillator control
  always @(posedge core_clk) begin
    if (rst) begin
      osc_en_d_r <= 1'h0;
    end else begin
      osc_en_d_r <= osc_en;
    end
  end

  // reload at each phase change and when the oscillator is just enabled;
  // while disabled the counter is held loaded so no stale tick ends a period
  always @* begin
    t_load = 1'h0;
    if (!osc_en) begin
      t_load = 1'h1;
    end else if (!osc_en_d_r) begin
      t_load = 1'h1;
    end else if (phase_nxt != phase_r) begin
      t_load = 1'h1;
    end
  end

  // on period length follows the bank that the next ON will use
  always @* begin
    t_val = {1'h0, off_time_field_a};
    if (phase_nxt == `CBS_PH_ON) begin
      if (status_nxt) begin
        t_val = on_time_field_a;
      end else begin
        t_val = on_time_field_b;
      end
    end
  end

  cbs_timer u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (t_load),
    .load_val (t_val),
    .done     (t_done)
  );

  // device state: OFF, or ON with the bank that status names.
  // configuration mode leaves the analog state as it was
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `CBS_ST_OFF: begin
        if (want_on && !cfg_mode) begin
          state_nxt = status_nxt ? `CBS_ST_A : `CBS_ST_B;
        end
      end
      `CBS_ST_A, `CBS_ST_B: begin
        if (hold || cfg_mode) begin
          state_nxt = state_r;
        end else if (!want_on) begin
          state_nxt = `CBS_ST_OFF;
        end else begin
          state_nxt = status_nxt ? `CBS_ST_A : `CBS_ST_B;
        end
      end
      default: begin
        state_nxt = `CBS_ST_OFF;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_r <= `CBS_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the same status flop feeds both register bank read paths
  assign active_bank_status = status_r;
  assign dev_state          = state_r;
  assign dev_on             = (state_r != `CBS_ST_OFF);
  assign cfg_bank_b         = (state_r == `CBS_ST_B);
  assign sched_on           = phase_r;
endmodule

//--- test/cbs_ctrl_props.sv
`timescale 1ns/1ps
`include "cbs_defines.vh"

// port-level watch on the bank switch controller
module cbs_ctrl_chk (
  input wire       core_clk,
  input wire       rst,
  input wire       bank_a_select,
  input wire       bank_b_select,
  input wire [7:0] config2_a,
  input wire       config_select_n,
  input wire       wake_pin,
  input wire       wake_pin_driven,
  input wire       spi_access,
  input wire       msg_active,
  input wire       active_bank_status,
  input wire [1:0] dev_state,
  input wire       dev_on
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // reset values and select take-over at config exit
  reset_vals_a: assert property (
    $fell(rst) |-> active_bank_status && dev_state == `CBS_ST_OFF) else $error("bad reset");
  single_exit_a: assert property (
    $rose(config_select_n) && !(bank_a_select && bank_b_select)
    |-> ##6 active_bank_status == !bank_b_select) else $error("select not applied");
  dual_exit_a: assert property (
    $rose(config_select_n) && bank_a_select && bank_b_select && wake_pin
    |-> ##6 active_bank_status) else $error("no restart at A");
  cfg_freeze_a: assert property (
    !config_select_n && !$past(config_select_n) && !spi_access && !config2_a[0]
    |-> $stable(active_bank_status)) else $error("status moved in config");
  // pin, message and oscillator override
  pin_low_off_a: assert property (
    (!wake_pin && (wake_pin_driven || !config2_a[0]) && !msg_active)[*6] |-> !dev_on)
    else $error("on with pin low");
  msg_hold_a: assert property (
    msg_active && dev_on |=> $stable(dev_state)) else $error("left state in message");
  pin_toggle_a: assert property (
    $fell(wake_pin) && !config2_a[0] && bank_a_select && bank_b_select && config_select_n
    |-> ##[2:5] $changed(active_bank_status)) else $error("no swap on fall");
  osc_freeze_a: assert property (
    (config2_a[0] && wake_pin_driven && wake_pin && config_select_n && !spi_access)[*8]
    |-> $stable(active_bank_status)) else $error("status moved while forced");
endmodule

bind cbs_ctrl cbs_ctrl_chk u_chk (.core_clk, .rst, .bank_a_select, .bank_b_select,
  .config2_a, .config_select_n, .wake_pin, .wake_pin_driven, .spi_access, .msg_active,
  .active_bank_status, .dev_state, .dev_on);

//--- test/cbs_host.sv
`timescale 1ns/1ps

// host side: config accesses and the wake pin
module cbs_host (
  input  wire core_clk,
  output reg  bank_a_select,
  output reg  bank_b_select,
  output reg  config_select_n,
  output reg  spi_access,
  output wire wake_pin,
  output reg  wake_pin_driven
);
  reg lvl_r = 1'h1;
  reg alt_r = 1'h0;
  initial {bank_a_select, bank_b_select, config_select_n, spi_access, wake_pin_driven} = 5'h05;
  // a floating pin moves every cycle so no stale level reads as driven
  always @(posedge core_clk) alt_r <= ~alt_r;
  assign wake_pin = wake_pin_driven ? lvl_r : alt_r;
  // dual selects are only ever written with the pin driven high
  task automatic cfg(input logic a, input logic b);
    @(posedge core_clk);
    config_select_n <= 1'h0;
    wake_pin_driven <= 1'h1;
    lvl_r <= 1'h1;
    bank_a_select <= a;
    bank_b_select <= b;
    repeat (4) @(posedge core_clk);
    config_select_n <= 1'h1;
    spi_access <= 1'h1;
    @(posedge core_clk) spi_access <= 1'h0;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic pin(input logic d, input logic v);
    @(posedge core_clk);
    wake_pin_driven <= d;
    lvl_r <= v;
  endtask
endmodule

//--- test/config_bank_switch_control_tb_top.sv
`timescale 1ns/1ps
`include "cbs_defines.vh"

module config_bank_switch_control_tb_top;
  logic        core_clk, rst, msg_active, active_bank_status, dev_on, cfg_bank_b, sched_on;
  logic        bank_a_select, bank_b_select, config_select_n, spi_access, wake_pin;
  logic        wake_pin_driven, s0, e;
  logic [7:0]  config2_a;
  logic [3:0]  on_time_field_a, on_time_field_b;
  logic [2:0]  off_time_field_a;
  logic [1:0]  dev_state;
  logic [31:0] seed = 32'h9;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          t0;

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  cbs_host u_host (.core_clk, .bank_a_select, .bank_b_select, .config_select_n,
    .spi_access, .wake_pin, .wake_pin_driven);
  cbs_ctrl u_dut (.core_clk, .rst, .bank_a_select, .bank_b_select, .config2_a,
    .tx_mode_flag(1'h0), .on_time_field_a, .on_time_field_b, .off_time_field_a,
    .config_select_n, .wake_pin, .wake_pin_driven, .spi_access, .msg_active,
    .active_bank_status, .dev_state, .dev_on, .cfg_bank_b, .sched_on);

  // expectations: xorshift stimulus, state code per bank, full schedule period
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [1:0] st(input logic b);
    return b ? `CBS_ST_B : `CBS_ST_A;
  endfunction
  function automatic int per(input logic [3:0] on, input logic [2:0] off);
    return (on + off + 2) * `CBS_TICK_CYC;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // sample a step after the edge so design updates have landed
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wlev(input logic v);
    int n;
    for (n = 0; n < 5000 && sched_on !== v; n++) w(1);
    if (n == 5000) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    rst = 1'h1;
    msg_active = 1'h0;
    config2_a = 8'h00;
    {on_time_field_a, on_time_field_b, off_time_field_a} = 11'h000;
    repeat (12) @(posedge core_clk);
    rst <= 1'h0;
    w(1);
    chk("reset status", active_bank_status, 1'h1);
    chk("reset sched", sched_on, 1'h0);
    // direct control over every single-bank select pair
    for (int i = 0; i < 3; i++) begin
      u_host.cfg(i[0], i[1]);
      w(1);
      chk("dir status", active_bank_status, !i[1]);
      chk("dir state", dev_state, st(i[1]));
      chk("dir bank", cfg_bank_b, i[1]);
    end
    // a message keeps state B past the pin fall
    u_host.pin(1'h1, 1'h0);
    w(6);
    chk("pin off", dev_state, `CBS_ST_OFF);
    u_host.pin(1'h1, 1'h1);
    w(6);
    msg_active <= 1'h1;
    u_host.pin(1'h1, 1'h0);
    w(8);
    chk("msg hold", dev_state, `CBS_ST_B);
    msg_active <= 1'h0;
    w(6);
    chk("msg end", dev_state, `CBS_ST_OFF);
    // dual on the pin: each fall swaps, then an access restarts at A
    u_host.cfg(1'h1, 1'h1);
    e = 1'h1;
    for (int i = 0; i < 3; i++) begin
      u_host.pin(1'h1, 1'h0);
      e = !e;
      u_host.pin(1'h1, 1'h1);
      w(6);
      chk("dual status", active_bank_status, e);
      chk("dual state", dev_state, st(!e));
    end
    u_host.cfg(1'h1, 1'h1);
    w(1);
    chk("dual restart", active_bank_status, 1'h1);
    // oscillator, bank A, random durations, messages must not shift the schedule
    u_host.cfg(1'h0, 1'h0);
    u_host.pin(1'h0, 1'h0);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      on_time_field_a <= {2'h0, seed[1:0]};
      on_time_field_b <= seed[7:4];
      off_time_field_a <= {1'h0, seed[3:2]};
      config2_a <= {seed[15:9], 1'h1};
      wlev(1'h0);
      wlev(1'h1);
      wlev(1'h0);
      wlev(1'h1);
      t0 = cyc;
      msg_active <= seed[8];
      w(4);
      chk("osc on", dev_on, 1'h1);
      wlev(1'h0);
      msg_active <= 1'h0;
      wlev(1'h1);
      chk("osc period", cyc - t0, per(on_time_field_a, off_time_field_a));
    end
    // oscillator dual: swap per ON period, forced pin freezes and overrides
    on_time_field_b <= 4'h1;
    u_host.cfg(1'h1, 1'h1);
    u_host.pin(1'h0, 1'h0);
    wlev(1'h0);
    wlev(1'h1);
    s0 = active_bank_status;
    wlev(1'h0);
    wlev(1'h1);
    chk("osc swap", active_bank_status, !s0);
    u_host.pin(1'h1, 1'h1);
    w(4);
    s0 = active_bank_status;
    w(3000);
    chk("osc freeze", active_bank_status, s0);
    chk("forced on", dev_state, st(!s0));
    u_host.pin(1'h1, 1'h0);
    w(6);
    chk("forced off", dev_on, 1'h0);
    end_of_test();
  end
endmodule
